/* hdl/dsg_pkg.sv */
// Package: register map, field layout and reset values of the status and GPIO block
package dsg_pkg;
   // ----------------------------------------------------------------
   // Register offsets (printed offsets are not word aligned: indices)
   // ----------------------------------------------------------------
   localparam logic [7:0]  IDX_LINK_STATUS = 8'h1C;
   localparam logic [7:0]  IDX_PIN0_CFG    = 8'h1D;
   localparam logic [7:0]  IDX_PIN12_CFG   = 8'h1E;
   localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h40;
   localparam logic [7:0]  IDX_IRQ_MASK    = 8'h41;
   localparam int          ADDR_W          = 12;
   localparam int          WORD_SHIFT      = 2;

   // ----------------------------------------------------------------
   // Status bit positions
   // ----------------------------------------------------------------
   localparam int ST_LOCK   = 0;
   localparam int ST_SIGDET = 1;
   localparam int ST_AUDLK  = 3;
   localparam int ST_RXDUAL = 4;
   localparam int ST_TXDUAL = 5;
   localparam logic [7:0] ST_USED_MASK = 8'h3B;
   localparam logic [7:0] ST_RESET     = 8'h00;

   // ----------------------------------------------------------------
   // Per-pin nibble layout: value, remote, direction, enable
   // ----------------------------------------------------------------
   localparam int PF_EN   = 0;
   localparam int PF_DIR  = 1;
   localparam int PF_REM  = 2;
   localparam int PF_VAL  = 3;
   localparam int NIB_W   = 4;
   localparam int NUM_PINS = 3;
   localparam logic [3:0] NIB_RST_NORMAL = 4'h0;
   localparam logic [3:0] NIB_RST_PORT1  = 4'h3;
   localparam logic [3:0] REVISION_FIELD = 4'h7; // Arbitrary value

   // ----------------------------------------------------------------
   // Pad modes from {direction, enable}
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_FUNC_OUT = 2'h0;
   localparam logic [1:0] MODE_GPIO_OUT = 2'h1;
   localparam logic [1:0] MODE_TRISTATE = 2'h2;
   localparam logic [1:0] MODE_GPIO_IN  = 2'h3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dsg_pkg

/* hdl/dsg_top.sv */
// Status register and three-pin GPIO configuration behind an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
module dsg_top
   import dsg_pkg::*;
#(
   parameter int NPINS = dsg_pkg::NUM_PINS
) (
   input  wire logic                      ref_clk_i,
   input  wire logic                      rstn_i,
   input  wire logic                      clk_en_i,
   // AXI4-Lite slave
   input  wire logic [dsg_pkg::ADDR_W-1:0] s_awaddr_i,
   input  wire logic                      s_awvalid_i,
   output logic                           s_awready_o,
   input  wire logic [31:0]               s_wdata_i,
   input  wire logic [3:0]                s_wstrb_i,
   input  wire logic                      s_wvalid_i,
   output logic                           s_wready_o,
   output logic [1:0]                     s_bresp_o,
   output logic                           s_bvalid_o,
   input  wire logic                      s_bready_i,
   input  wire logic [dsg_pkg::ADDR_W-1:0] s_araddr_i,
   input  wire logic                      s_arvalid_i,
   output logic                           s_arready_o,
   output logic [31:0]                    s_rdata_o,
   output logic [1:0]                     s_rresp_o,
   output logic                           s_rvalid_o,
   input  wire logic                      s_rready_i,
   // Link status inputs
   input  wire logic                      tx_two_link_flag_i,
   input  wire logic                      rx_two_link_flag_i,
   input  wire logic                      audio_pll_lock_i,
   input  wire logic                      signal_detect_i,
   input  wire logic [1:0]                chan_lock_i,
   // Port select, global GPIO setting, remote values
   input  wire logic                      second_port_select_i,
   input  wire logic                      global_direction_i,
   input  wire logic                      global_enable_i,
   input  wire logic                      global_out_value_i,
   input  wire logic [NPINS-1:0]          remote_value_i,
   input  wire logic [NPINS-1:0]          func_out_i,
   // Primary pins
   input  wire logic [NPINS-1:0]          pin_i,
   output logic [NPINS-1:0]               pin_o,
   output logic [NPINS-1:0]               pin_oe_o,
   // Second-port pins
   input  wire logic [NPINS-1:0]          second_port_pin_i,
   output logic [NPINS-1:0]               second_port_pin_o,
   output logic [NPINS-1:0]               second_port_pin_oe_o,
   output logic [NPINS-1:0]               gpio_in_value_o,
   output logic                           irq_o
);
   import dsg_pkg::*;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
      word_index = a[WORD_SHIFT +: 8];
   endfunction : word_index

   function automatic logic idx_mapped(input logic [7:0] i);
      idx_mapped = (i == IDX_LINK_STATUS) || (i == IDX_PIN0_CFG) || (i == IDX_PIN12_CFG)
                   || (i == IDX_IRQ_STATUS) || (i == IDX_IRQ_MASK);
   endfunction : idx_mapped

   // ----------------------------------------------------------------
   // Status sampling
   // ----------------------------------------------------------------
   logic [7:0] status_ff;
   logic [7:0] nxt_status;
   logic       lock_now;

   // Dual link counts as locked only when both channels are
   assign lock_now = rx_two_link_flag_i ? (&chan_lock_i) : chan_lock_i[0];

   always_comb begin
      nxt_status            = ST_RESET;
      nxt_status[ST_TXDUAL] = tx_two_link_flag_i;
      nxt_status[ST_RXDUAL] = rx_two_link_flag_i;
      nxt_status[ST_AUDLK]  = audio_pll_lock_i;
      nxt_status[ST_SIGDET] = signal_detect_i;
      nxt_status[ST_LOCK]   = lock_now;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         status_ff <= ST_RESET;
      end else if (clk_en_i) begin
         status_ff <= nxt_status & ST_USED_MASK;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   logic                  aw_held_ff;
   logic                  w_held_ff;
   logic [ADDR_W-1:0]     awaddr_ff;
   logic [31:0]           wdata_ff;
   logic [3:0]            wstrb_ff;
   logic                  bvalid_ff;
   logic [1:0]            bresp_ff;
   logic                  wr_fire;
   logic [7:0]            wr_idx;
   logic                  wr_lane0;
   logic                  nxt_aw_held;
   logic                  nxt_w_held;
   logic                  nxt_bvalid;

   // Ready lines are registered inverses of the next busy state
   assign nxt_aw_held = (s_awvalid_i && s_awready_o) || (aw_held_ff && !wr_fire);
   assign nxt_w_held  = (s_wvalid_i && s_wready_o) || (w_held_ff && !wr_fire);
   assign nxt_bvalid  = wr_fire || (bvalid_ff && !s_bready_i);
   assign wr_fire     = aw_held_ff && w_held_ff && !bvalid_ff && clk_en_i;
   assign wr_idx      = word_index(awaddr_ff);
   assign wr_lane0    = wstrb_ff[0];
   assign s_bvalid_o  = bvalid_ff;
   assign s_bresp_o   = bresp_ff;

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         s_awready_o <= 1'b1;
         s_wready_o  <= 1'b1;
      end else if (clk_en_i) begin
         s_awready_o <= !nxt_aw_held && !nxt_bvalid;
         s_wready_o  <= !nxt_w_held && !nxt_bvalid;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         aw_held_ff <= 1'b0;
         awaddr_ff  <= '0;
      end else if (clk_en_i) begin
         if (s_awvalid_i && s_awready_o) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_awaddr_i;
         end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         w_held_ff <= 1'b0;
         wdata_ff  <= '0;
         wstrb_ff  <= '0;
      end else if (clk_en_i) begin
         if (s_wvalid_i && s_wready_o) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_wdata_i;
            wstrb_ff  <= s_wstrb_i;
         end else if (wr_fire) begin
            w_held_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (clk_en_i) begin
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_bready_i) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [NIB_W-1:0] pin_cfg_ff [NPINS];
   logic             port_sel_ff;
   logic [NIB_W-1:0] rst_nib;

   // Strap is taken while reset is held, so it is a clocked capture
   assign rst_nib = second_port_select_i ? NIB_RST_PORT1 : NIB_RST_NORMAL;

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         port_sel_ff <= second_port_select_i;
      end else if (clk_en_i) begin
         port_sel_ff <= second_port_select_i;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NPINS; g++) begin : g_cfg
         // Pin0 in 0x1D low nibble; pins 1,2 share 0x1E low/high nibble
         localparam logic [7:0] CFG_IDX = (g == 0) ? IDX_PIN0_CFG : IDX_PIN12_CFG;
         localparam int         NIB_LO  = (g == 2) ? NIB_W : 0;
         always_ff @(posedge ref_clk_i) begin
            if (!rstn_i) begin
               pin_cfg_ff[g] <= rst_nib;
            end else if (clk_en_i && wr_fire && wr_lane0 && (wr_idx == CFG_IDX)) begin
               pin_cfg_ff[g] <= wdata_ff[NIB_LO +: NIB_W];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Interrupts: status bit changes latch sticky, write one to clear
   // ----------------------------------------------------------------
   logic [7:0] irq_status_ff;
   logic [7:0] irq_mask_ff;
   logic [7:0] status_event;
   logic [7:0] irq_clr;

   assign status_event = (status_ff ^ nxt_status) & ST_USED_MASK;
   assign irq_clr = (wr_fire && wr_lane0 && wr_idx == IDX_IRQ_STATUS) ? wdata_ff[7:0] : 8'h00;

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         irq_status_ff <= 8'h00;
         irq_mask_ff   <= 8'h00;
         irq_o         <= 1'b0;
      end else if (clk_en_i) begin
         // Set wins over a simultaneous clear
         irq_status_ff <= (irq_status_ff & ~irq_clr) | status_event;
         if (wr_fire && wr_lane0 && wr_idx == IDX_IRQ_MASK) begin
            irq_mask_ff <= wdata_ff[7:0] & ST_USED_MASK;
         end
         irq_o <= |((irq_status_ff & ~irq_clr | status_event) & irq_mask_ff);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic [7:0]  rd_idx;
   logic [7:0]  rd_byte;

   assign rd_idx      = word_index(s_araddr_i);
   assign s_rvalid_o  = rvalid_ff;
   assign s_rdata_o   = rdata_ff;
   assign s_rresp_o   = rresp_ff;

   always_comb begin
      rd_byte = 8'h00;
      if (rd_idx == IDX_LINK_STATUS) begin
         rd_byte = status_ff;
      end else if (rd_idx == IDX_PIN0_CFG) begin
         rd_byte = {REVISION_FIELD, pin_cfg_ff[0]};
      end else if (rd_idx == IDX_PIN12_CFG) begin
         rd_byte = {pin_cfg_ff[2], pin_cfg_ff[1]};
      end else if (rd_idx == IDX_IRQ_STATUS) begin
         rd_byte = irq_status_ff;
      end else if (rd_idx == IDX_IRQ_MASK) begin
         rd_byte = irq_mask_ff;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= '0;
         rresp_ff  <= RESP_OKAY;
         s_arready_o <= 1'b1;
      end else if (clk_en_i) begin
         // Low from the taking edge until the read data is accepted
         s_arready_o <= !((s_arvalid_i && s_arready_o) || (rvalid_ff && !s_rready_i));
         if (s_arvalid_i && s_arready_o) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= {24'h000000, rd_byte};
            rresp_ff  <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_rready_i) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pad control
   // ----------------------------------------------------------------
   logic [NPINS-1:0] nxt_drv;
   logic [NPINS-1:0] nxt_oe;
   logic [NPINS-1:0] nxt_in;
   logic [NPINS-1:0] pad_drv_ff;
   logic [NPINS-1:0] pad_oe_ff;

   always_comb begin
      nxt_drv = '0;
      nxt_oe  = '0;
      nxt_in  = '0;
      for (int p = 0; p < NPINS; p++) begin
         logic [1:0] mode;
         logic       pin_val;
         mode    = {pin_cfg_ff[p][PF_DIR], pin_cfg_ff[p][PF_EN]};
         pin_val = port_sel_ff ? second_port_pin_i[p] : pin_i[p];
         // Pin bits left at functional mode defer to the global setting
         if (mode == MODE_FUNC_OUT) begin
            mode = {global_direction_i, global_enable_i};
         end
         if (pin_cfg_ff[p][PF_REM]) begin
            nxt_oe[p]  = 1'b1;
            nxt_drv[p] = remote_value_i[p];
         end else begin
            // Remote values are not looked at here
            unique case (mode)
               MODE_FUNC_OUT: begin
                  nxt_oe[p]  = 1'b1;
                  nxt_drv[p] = func_out_i[p];
               end
               MODE_GPIO_OUT: begin
                  nxt_oe[p]  = 1'b1;
                  nxt_drv[p] = (mode == {pin_cfg_ff[p][PF_DIR], pin_cfg_ff[p][PF_EN]})
                               ? pin_cfg_ff[p][PF_VAL] : global_out_value_i;
               end
               MODE_TRISTATE: begin
                  nxt_oe[p] = 1'b0;
               end
               MODE_GPIO_IN: begin
                  nxt_oe[p] = 1'b0;
                  nxt_in[p] = pin_val;
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         pad_drv_ff      <= '0;
         pad_oe_ff       <= '0;
         gpio_in_value_o <= '0;
      end else if (clk_en_i) begin
         pad_drv_ff      <= nxt_drv;
         pad_oe_ff       <= nxt_oe;
         gpio_in_value_o <= nxt_in;
      end
   end

   // Unselected pin set stays released
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         pin_o                <= '0;
         pin_oe_o             <= '0;
         second_port_pin_o    <= '0;
         second_port_pin_oe_o <= '0;
      end else if (clk_en_i) begin
         pin_o                <= port_sel_ff ? '0 : nxt_drv;
         pin_oe_o             <= port_sel_ff ? '0 : nxt_oe;
         second_port_pin_o    <= port_sel_ff ? nxt_drv : '0;
         second_port_pin_oe_o <= port_sel_ff ? nxt_oe : '0;
      end
   end
endmodule : dsg_top
`default_nettype wire

/* testbench/deser_status_and_gpio_config_test.sv */
// Self-checking bench: register access, status bits, pin modes and interrupt
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin n_mismatch++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, (act), (exp)); end end
module deser_status_and_gpio_config_test;
   import dsg_pkg::*;
   logic        ref_clk, rstn, sel, gdir, gen, gval, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, chl;
   logic [5:0]  link_cfg;
   logic [2:0]  rem_val, func_out, pin_in, sp_in, pin_out, pin_oe, sp_out, sp_oe, gin;
   logic        tx2, rx2, aud, sig, clk_en;
   logic [2:0]  remote_value;
   int          n_mismatch, n_tests;

   dsg_remote_model u_remote (.ref_clk_i(ref_clk), .link_cfg_i(link_cfg), .rem_val_i(rem_val),
      .tx_two_link_flag_o(tx2), .rx_two_link_flag_o(rx2), .audio_pll_lock_o(aud),
      .signal_detect_o(sig), .chan_lock_o(chl), .remote_value_o(remote_value));

   dsg_top dut (
      .ref_clk_i(ref_clk), .rstn_i(rstn), .clk_en_i(clk_en),
      .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
      .s_wdata_i(wdata), .s_wstrb_i(4'hF), .s_wvalid_i(wvalid), .s_wready_o(wready),
      .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
      .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
      .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
      .tx_two_link_flag_i(tx2), .rx_two_link_flag_i(rx2), .audio_pll_lock_i(aud),
      .signal_detect_i(sig), .chan_lock_i(chl), .second_port_select_i(sel),
      .global_direction_i(gdir), .global_enable_i(gen), .global_out_value_i(gval),
      .remote_value_i(remote_value), .func_out_i(func_out), .pin_i(pin_in),
      .pin_o(pin_out), .pin_oe_o(pin_oe), .second_port_pin_i(sp_in),
      .second_port_pin_o(sp_out), .second_port_pin_oe_o(sp_oe),
      .gpio_in_value_o(gin), .irq_o(irq)
   );

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Bus tasks: each returns just after the edge that took the answer
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er,
                         input int lag = 0);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= (lag == 0);
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         // A late ready leaves the answer waiting for some cycles
         if (lag > 0) begin
            lag--;
            if (lag == 0) bready <= 1'b1;
         end
      end while (!(bvalid === 1'b1 && bready === 1'b1));
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask : axi_wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                         input logic [1:0] er = RESP_OKAY, input int lag = 0);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (lag == 0);
      do begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (lag > 0) begin
            lag--;
            if (lag == 0) rready <= 1'b1;
         end
      end while (!(rvalid === 1'b1 && rready === 1'b1));
      rready <= 1'b0;
      `CHK(rdata, e)
      `CHK(rresp, er)
   endtask : rd_chk

   task automatic do_reset(input logic s);
      sel <= s;
      rstn <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
   endtask : do_reset

   // Pad results settle one edge after the write lands
   task automatic pin_case(input logic [7:0] n0, n12, input logic [2:0] g, eoe, eo, egin);
      {gdir, gen, gval} <= g;
      axi_wr(12'h074, {24'h0, n0}, RESP_OKAY);
      axi_wr(12'h078, {24'h0, n12}, RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      `CHK(sel ? sp_oe : pin_oe, eoe)
      `CHK((sel ? sp_out : pin_out) & eoe, eo)
      `CHK(gin, egin)
      `CHK(sel ? pin_oe : sp_oe, 3'h0)
   endtask : pin_case

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      rstn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready, gdir, gen, gval, sel} = '0;
      clk_en = 1'b1;
      link_cfg = 6'h00;
      rem_val = 3'h3;
      func_out = 3'h5;
      pin_in = 3'h5;
      sp_in = 3'h3;
      do_reset(1'b0);
      rd_chk(12'h070, 32'h0);
      rd_chk(12'h074, {24'h0, REVISION_FIELD, 4'h0});
      rd_chk(12'h078, 32'h0);
      for (int i = 0; i < 64; i++) begin
         link_cfg <= i[5:0];
         repeat (3) @(posedge ref_clk);
         rd_chk(12'h070, {26'h0, i[5:3], 1'b0, i[2], i[4] ? &i[1:0] : i[0]});
      end
      axi_wr(12'h070, 32'hFF, RESP_OKAY);
      rd_chk(12'h070, 32'h3B);
      axi_wr(12'h200, 32'hFF, RESP_SLVERR);
      rd_chk(12'h200, 32'h0, RESP_SLVERR);
      pin_case(8'h00, 8'h00, 3'h0, 3'h7, 3'h5, 3'h0);
      // Enable low: pads hold although the global setting moves
      clk_en <= 1'b0;
      {gdir, gen} <= 2'h2;
      repeat (3) @(posedge ref_clk);
      `CHK(pin_oe, 3'h7)
      clk_en <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK(pin_oe, 3'h0)
      pin_case(8'h00, 8'h00, 3'h3, 3'h7, 3'h7, 3'h0);
      pin_case(8'h00, 8'h00, 3'h4, 3'h0, 3'h0, 3'h0);
      pin_case(8'h09, 8'h99, 3'h0, 3'h7, 3'h7, 3'h0);
      pin_case(8'h01, 8'h11, 3'h0, 3'h7, 3'h0, 3'h0);
      pin_case(8'h0A, 8'hAA, 3'h0, 3'h0, 3'h0, 3'h0);
      pin_case(8'h03, 8'h33, 3'h0, 3'h0, 3'h0, 3'h5);
      pin_case(8'h04, 8'h44, 3'h0, 3'h7, 3'h3, 3'h0);
      pin_case(8'hF3, 8'h19, 3'h0, 3'h6, 3'h2, 3'h1);
      rd_chk(12'h074, {24'h0, REVISION_FIELD, 4'h3});
      // Interrupt: raise on a status change, mask, unmask, clear
      axi_wr(12'h100, 32'hFF, RESP_OKAY);
      rd_chk(12'h100, 32'h0);
      axi_wr(12'h104, 32'h02, RESP_OKAY, 3);
      rd_chk(12'h104, 32'h02, RESP_OKAY, 2);
      link_cfg <= link_cfg ^ 6'h04;
      repeat (5) @(posedge ref_clk);
      `CHK(irq, 1'b1)
      rd_chk(12'h100, 32'h02);
      axi_wr(12'h104, 32'h00, RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      axi_wr(12'h104, 32'h02, RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      `CHK(irq, 1'b1)
      axi_wr(12'h100, 32'h02, RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      rd_chk(12'h100, 32'h0);
      // Second pin set
      do_reset(1'b1);
      rd_chk(12'h074, {24'h0, REVISION_FIELD, 4'h3});
      rd_chk(12'h078, 32'h33);
      pin_case(8'h03, 8'h33, 3'h0, 3'h0, 3'h0, 3'h3);
      pin_case(8'h09, 8'h11, 3'h0, 3'h7, 3'h1, 3'h0);
      end_sim();
   end

   // Whole run is near 500 cycles; allow a wide margin
   initial begin
      repeat (8000) @(posedge ref_clk);
      n_mismatch++;
      end_sim();
   end
endmodule : deser_status_and_gpio_config_test
`default_nettype wire

/* testbench/dsg_remote_model.sv */
// Behavioural model of the far serializer: link state and forwarded pin values
`timescale 1ns/10ps
`default_nettype none
module dsg_remote_model (
   input  wire logic       ref_clk_i,
   input  wire logic [5:0] link_cfg_i,
   input  wire logic [2:0] rem_val_i,
   output logic            tx_two_link_flag_o,
   output logic            rx_two_link_flag_o,
   output logic            audio_pll_lock_o,
   output logic            signal_detect_o,
   output logic [1:0]      chan_lock_o,
   output logic [2:0]      remote_value_o
);
   // Link state moves one edge after it is asked for, never in the same step
   initial begin
      {tx_two_link_flag_o, rx_two_link_flag_o, audio_pll_lock_o} = 3'h0;
      {signal_detect_o, chan_lock_o, remote_value_o} = 6'h00;
   end
   always @(posedge ref_clk_i) begin
      {tx_two_link_flag_o, rx_two_link_flag_o, audio_pll_lock_o, signal_detect_o,
       chan_lock_o} <= link_cfg_i;
      remote_value_o <= rem_val_i;
   end
endmodule : dsg_remote_model
`default_nettype wire

/* testbench/dsg_top_assertions.sv */
// Checker: bus handshake timing and pin-set routing of the status and GPIO block
`timescale 1ns/10ps
`default_nettype none
module dsg_top_checker #(
   parameter int NPINS = 3
) (
   input wire logic             ref_clk_i,
   input wire logic             rstn_i,
   input wire logic             clk_en_i,
   input wire logic             s_awvalid_i,
   input wire logic             s_awready_o,
   input wire logic             s_wvalid_i,
   input wire logic             s_wready_o,
   input wire logic [1:0]       s_bresp_o,
   input wire logic             s_bvalid_o,
   input wire logic             s_bready_i,
   input wire logic             s_arvalid_i,
   input wire logic             s_arready_o,
   input wire logic [31:0]      s_rdata_o,
   input wire logic [1:0]       s_rresp_o,
   input wire logic             s_rvalid_o,
   input wire logic             s_rready_i,
   input wire logic             second_port_select_i,
   input wire logic [NPINS-1:0] pin_o,
   input wire logic [NPINS-1:0] pin_oe_o,
   input wire logic [NPINS-1:0] second_port_pin_o,
   input wire logic [NPINS-1:0] second_port_pin_oe_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   a_bresp_holds: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
      else $error("write response dropped before it was taken");
   a_write_answer: assert property (s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o
      && clk_en_i ##1 clk_en_i |=> s_bvalid_o) else $error("write response late");
   a_read_answer: assert property (s_arvalid_i && s_arready_o && clk_en_i |=> s_rvalid_o)
      else $error("read data late");
   a_rdata_holds: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
      else $error("read data dropped before it was taken");
   a_ar_blocked: assert property (s_rvalid_o |-> !s_arready_o)
      else $error("read address accepted while data pending");
   a_aw_blocked: assert property (s_bvalid_o |-> !s_awready_o && !s_wready_o)
      else $error("write accepted while response pending");
   a_rdata_byte: assert property (s_rvalid_o |-> s_rdata_o[31:8] == 24'h0 && !s_rresp_o[0])
      else $error("read word has upper bits or bad response");
   a_primary_quiet: assert property (
      (second_port_select_i && clk_en_i) [*3] |-> pin_oe_o == '0 && pin_o == '0)
      else $error("primary pins driven while second set selected");
   a_second_quiet: assert property (
      (!second_port_select_i && clk_en_i) [*3] |-> second_port_pin_oe_o == '0
      && second_port_pin_o == '0) else $error("second-port pins driven while unselected");
endmodule : dsg_top_checker

bind dsg_top dsg_top_checker #(.NPINS(NPINS)) u_chk (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
   .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o), .s_wvalid_i(s_wvalid_i),
   .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o),
   .s_bready_i(s_bready_i), .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o),
   .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o), .s_rvalid_o(s_rvalid_o),
   .s_rready_i(s_rready_i), .second_port_select_i(second_port_select_i),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .second_port_pin_o(second_port_pin_o),
   .second_port_pin_oe_o(second_port_pin_oe_o)
);
`default_nettype wire
